// ===== common/cmp_if.sv
/*
  Carrier between the encoder, the top and the edge generator:
  compare value with its load strobe plus the generator settings.
  Assumes all signals live in the pclk domain.
*/
`timescale 1ns/1ps
interface cmp_if;
  logic [31:0] compare;
  logic load;
  logic [15:0] period;
  logic [7:0] scale;
  logic fast;
  logic enable;
  modport src (output compare, output load);
  modport dst (input compare, input load, input period, input scale,
    input fast, input enable);
endinterface

// ===== common/dcl_pkg.sv
/*
  Shared constants for the duty-cycle word transmitter: register map,
  field positions, reset values and fixed-point encoding constants.
  Assumes a 100 MHz pclk and a 32-bit APB register bus.
*/
package dcl_pkg;
  // ==========================================================
  // register map (byte offsets)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_RES = 8'h04;
  localparam logic [7:0] A_FREQ = 8'h08;
  localparam logic [7:0] A_SAMPLE = 8'h0c;
  localparam logic [7:0] A_MANUAL = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_PERIOD = 8'h18;
  localparam logic [7:0] A_COMPARE = 8'h1c;
  localparam logic [7:0] A_SCALE = 8'h20;
  // ==========================================================
  // fields
  localparam int CTRL_SRC = 0;
  localparam int CTRL_CLK = 1;
  localparam int CTRL_EN = 2;
  localparam int ST_CALERR = 0;
  localparam int ST_DIVBUSY = 1;
  localparam int ST_CALWAIT = 2;
  localparam int RES_W = 5;
  localparam int WORD_W = 16;
  localparam int FRAC_W = 16;
  // ==========================================================
  // reset values
  localparam logic [2:0] CTRL_DEF = 3'h4;
  localparam logic [RES_W-1:0] RES_DEF = 5'd11;
  localparam logic [RES_W-1:0] RES_MAX = 5'd16;
  localparam logic [15:0] FREQ_KHZ_DEF = 16'd200;
  localparam logic [15:0] SAMPLE_KHZ_DEF = 16'd25;
  localparam logic [7:0] SCALE_DEF = 8'h40;
  // ==========================================================
  // clocks and rates in kHz
  localparam logic [17:0] MOD_KHZ_SLOW = 18'd100000;
  localparam logic [17:0] MOD_KHZ_FAST = 18'd200000;
  localparam logic [16:0] PCLK_KHZ = 17'd100000;
  localparam logic [4:0] DIV_STEPS = 5'd18;
  localparam logic [15:0] STEP_SLOW = 16'h0001;
  localparam logic [15:0] STEP_FAST = 16'h0002;
  // ==========================================================
  // encoding: duty in Q0.24, 0.1 and 0.8 of full scale
  localparam logic [23:0] DUTY_LO = 24'd1677722;
  localparam logic [23:0] DUTY_SPAN = 24'd13421773;
  localparam logic [39:0] CMP_ROUND = 40'h80;
  localparam int CMP_SHIFT = 8;
  localparam logic [23:0] FRAC_ROUND = 24'h8000;
  localparam logic [8:0] STEP_MAX = 9'd255;
  typedef enum logic [0:0] {CAL_REQ = 1'b0, CAL_WAIT = 1'b1} cal_state_t;
endpackage

// ===== core/duty_encoder.sv
/*
  Two-stage encoder from a data word to a 16.16 compare value.
  Assumes go is a one-cycle pulse in the pclk domain with word valid.
*/
`timescale 1ns/1ps
module duty_encoder
  import dcl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [WORD_W-1:0] word,
  input wire logic [RES_W-1:0] shift,
  input wire logic [15:0] period,
  cmp_if.src cmp
);
  logic [WORD_W:0] lim;
  logic [WORD_W-1:0] w_cl;
  logic [39:0] span;
  logic [23:0] duty_nxt;
  logic [23:0] duty_r;
  logic [15:0] per_r;
  logic v1_r;
  logic [39:0] prod;

  // ==========================================================
  // stage 1: duty = 0.1 + 0.8 * word / 2^res
  always_comb
  begin
    lim = (17'h00001 << shift) - 17'h00001;
    w_cl = (17'(word) > lim) ? lim[WORD_W-1:0] : word;
    span = (40'(w_cl) * 40'(DUTY_SPAN)) >> shift;
    duty_nxt = DUTY_LO + span[23:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      duty_r <= 24'h000000;
      per_r <= 16'h0000;
      v1_r <= 1'b0;
    end
    else
    begin
      v1_r <= go;
      if (go)
      begin
        duty_r <= duty_nxt;
        per_r <= period;
      end
    end
  end

  // ==========================================================
  // stage 2: compare = duty * period * 2^16 + 0.5
  // rounded compare word
  assign prod = 40'(duty_r) * 40'(per_r) + CMP_ROUND;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp.compare <= 32'h00000000;
      cmp.load <= 1'b0;
    end
    else
    begin
      cmp.load <= v1_r;
      if (v1_r)
        cmp.compare <= prod[CMP_SHIFT+31:CMP_SHIFT];
    end
  end
endmodule

// ===== core/duty_word_tx.sv
/*
  Duty-cycle word transmitter: APB registers, period divider, sample
  trigger, source select, background fine-step calibration, encoder
  and fixed-period edge generator.
  Assumes converter and delay-line calibration signals are pclk logic.
*/
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module duty_word_tx
  import dcl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [WORD_W-1:0] conv_word,
  input wire logic conv_done,
  output logic sample_trig,
  input wire logic [8:0] cal_steps,
  input wire logic cal_done,
  output logic cal_start,
  output logic pulse_out,
  output logic [7:0] fine_pos
);
  logic [2:0] ctrl_r;
  logic [RES_W-1:0] res_r;
  logic [RES_W-1:0] norm_shift_r;
  logic [15:0] freq_r;
  logic [15:0] sample_r;
  logic [WORD_W-1:0] manual_r;
  logic cal_err_r;
  logic [7:0] scale_r;
  logic [15:0] period_r;
  logic div_req_r;
  logic div_busy_r;
  logic div_done_r;
  logic [4:0] div_cnt_r;
  logic [17:0] div_rem_r;
  logic [17:0] div_quo_r;
  logic [17:0] rem_sh;
  logic [17:0] quo_sh;
  logic [16:0] acc_r;
  logic [17:0] acc_sum;
  logic tick;
  logic enc_go;
  logic [WORD_W-1:0] enc_word;
  logic setup;
  logic wr;
  logic [31:0] rd_data;
  cal_state_t cal_state_r;
  cmp_if cif ();

  // ==========================================================
  // address decode
  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      A_CTRL, A_RES, A_FREQ, A_SAMPLE, A_MANUAL,
      A_STATUS, A_PERIOD, A_COMPARE, A_SCALE: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  function automatic logic wr_to(input logic [7:0] a, input logic [7:0] t);
    wr_to = (a == t);
  endfunction

  // ==========================================================
  // apb slave: answer in the first access cycle
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite;

  always_comb
  begin
    rd_data = 32'h00000000;
    case (paddr)
      A_CTRL: rd_data = 32'(ctrl_r);
      A_RES: rd_data = 32'(res_r);
      A_FREQ: rd_data = 32'(freq_r);
      A_SAMPLE: rd_data = 32'(sample_r);
      A_MANUAL: rd_data = 32'(manual_r);
      A_STATUS: rd_data = 32'({(cal_state_r == CAL_WAIT), div_busy_r, cal_err_r});
      A_PERIOD: rd_data = 32'(period_r);
      A_COMPARE: rd_data = cif.compare;
      A_SCALE: rd_data = 32'(scale_r);
      default: rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !reg_hit(paddr);
      if (setup && !pwrite)
        prdata <= rd_data;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // module clock defaults to 100 MHz
      ctrl_r <= CTRL_DEF;
      manual_r <= '0;
    end
    else if (wr && wr_to(paddr, A_CTRL))
      ctrl_r <= pwdata[2:0];
    else if (wr && wr_to(paddr, A_MANUAL))
      manual_r <= pwdata[WORD_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_r <= RES_DEF;
      norm_shift_r <= RES_DEF;
    end
    else
    begin
      if (wr && wr_to(paddr, A_RES))
        res_r <= (pwdata[RES_W-1:0] > RES_MAX) ? RES_MAX : pwdata[RES_W-1:0];
      // scale factor follows every resolution change
      norm_shift_r <= res_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      freq_r <= FREQ_KHZ_DEF;
    else if (wr && wr_to(paddr, A_FREQ) && pwdata[15:0] != 16'h0000)
      freq_r <= pwdata[15:0];
  end

  // sample rate above transmit frequency only in the cycle after a lower one is written
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sample_r <= SAMPLE_KHZ_DEF;
    else if (wr && wr_to(paddr, A_SAMPLE))
      sample_r <= (pwdata[15:0] > freq_r) ? freq_r : pwdata[15:0];
    else if (sample_r > freq_r)
      sample_r <= freq_r;
  end

  // ==========================================================
  // period = module clock / frequency, restoring divider
  // a new frequency or clock choice restarts it; the old period runs on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_req_r <= 1'b0;
    else
      div_req_r <= wr && (wr_to(paddr, A_FREQ) || wr_to(paddr, A_CTRL));
  end

  assign rem_sh = {div_rem_r[16:0], div_quo_r[17]};
  assign quo_sh = {div_quo_r[16:0], (rem_sh >= 18'(freq_r))};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_busy_r <= 1'b1;
      div_cnt_r <= DIV_STEPS;
      div_rem_r <= '0;
      div_quo_r <= MOD_KHZ_SLOW;
      div_done_r <= 1'b0;
      period_r <= '0;
    end
    else
    begin
      div_done_r <= 1'b0;
      if (div_req_r)
      begin
        div_busy_r <= 1'b1;
        div_cnt_r <= DIV_STEPS;
        div_rem_r <= '0;
        div_quo_r <= ctrl_r[CTRL_CLK] ? MOD_KHZ_FAST : MOD_KHZ_SLOW;
      end
      else if (div_busy_r)
      begin
        div_rem_r <= quo_sh[0] ? rem_sh - 18'(freq_r) : rem_sh;
        div_quo_r <= quo_sh;
        div_cnt_r <= div_cnt_r - 5'd1;
        if (div_cnt_r == 5'd1)
        begin
          div_busy_r <= 1'b0;
          div_done_r <= 1'b1;
          period_r <= (quo_sh[17:16] != 2'b00) ? 16'hffff : quo_sh[15:0];
        end
      end
    end
  end

  // ==========================================================
  // sample trigger by phase accumulation at pclk
  // one spare bit: a high sample rate on top of the residue would wrap
  assign acc_sum = 18'(acc_r) + 18'(sample_r);
  assign tick = acc_sum >= 18'(PCLK_KHZ);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_r <= '0;
      sample_trig <= 1'b0;
    end
    else
    begin
      // trigger at the configured sample rate
      acc_r <= tick ? 17'(acc_sum - 18'(PCLK_KHZ)) : acc_sum[16:0];
      sample_trig <= tick;
    end
  end

  // ==========================================================
  // encoding pass source
  // source select picks manual or converter word
  assign enc_word = ctrl_r[CTRL_SRC] ? conv_word : manual_r;
  // one pass per conversion (manual: per trigger), plus one when the divider delivers a new period
  assign enc_go = div_done_r || (ctrl_r[CTRL_SRC] ? conv_done : sample_trig);

  duty_encoder u_enc (
    .pclk(pclk),
    .presetn(presetn),
    .go(enc_go),
    .word(enc_word),
    .shift(norm_shift_r),
    .period(period_r),
    .cmp(cif.src)
  );

  // ==========================================================
  // background fine-step calibration, restarted after every result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cal_state_r <= CAL_REQ;
      cal_start <= 1'b0;
      scale_r <= SCALE_DEF;
    end
    else
    begin
      cal_start <= 1'b0;
      case (cal_state_r)
        CAL_REQ:
        begin
          cal_start <= 1'b1;
          cal_state_r <= CAL_WAIT;
        end
        CAL_WAIT:
        begin
          if (cal_done)
          begin
            if (cal_steps <= STEP_MAX)
              scale_r <= cal_steps[7:0];
            cal_state_r <= CAL_REQ;
          end
        end
        default: cal_state_r <= CAL_REQ;
      endcase
    end
  end

  // an error keeps the last good scale; set wins over a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_err_r <= 1'b0;
    else if (cal_state_r == CAL_WAIT && cal_done && cal_steps > STEP_MAX)
      cal_err_r <= 1'b1;
    else if (wr && wr_to(paddr, A_STATUS) && pwdata[ST_CALERR])
      cal_err_r <= 1'b0;
  end

  // ==========================================================
  // edge generator
  assign cif.period = period_r;
  assign cif.scale = scale_r;
  assign cif.fast = ctrl_r[CTRL_CLK];
  assign cif.enable = ctrl_r[CTRL_EN];

  // generator applies compare at period boundary
  fine_edge_gen u_gen (
    .pclk(pclk),
    .presetn(presetn),
    .cmp(cif.dst),
    .pulse_out(pulse_out),
    .fine_pos(fine_pos)
  );
endmodule

// ===== core/fine_edge_gen.sv
/*
  Fixed-period pulse generator with shadowed compare and a fine
  falling-edge delay code for an external tap delay line.
  Assumes cmp.load is a one-cycle pulse; fine_pos drives the delay line.
*/
`timescale 1ns/1ps
module fine_edge_gen
  import dcl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  cmp_if.dst cmp,
  output logic pulse_out,
  output logic [7:0] fine_pos
);
  logic [15:0] cnt_r;
  logic [15:0] step;
  logic wrap;
  logic pend_r;
  logic [31:0] pend_cmp_r;
  logic [31:0] cmp_sh_r;
  logic [15:0] per_sh_r;
  logic en_sh_r;
  logic [31:0] next_cmp;
  logic [23:0] fine_raw;
  logic [8:0] fine_sum;
  logic [15:0] coarse;

  assign step = cmp.fast ? STEP_FAST : STEP_SLOW;
  assign wrap = (17'(cnt_r) + 17'(step)) >= 17'(per_sh_r);
  assign next_cmp = pend_r ? pend_cmp_r : cmp_sh_r;
  // only the falling edge moves; rising edge at count zero
  assign coarse = cmp.fast ? {cmp_sh_r[31:17], 1'b0} : cmp_sh_r[31:16];

  // ==========================================================
  // fine steps from the fraction and the calibrated step scale
  always_comb
  begin
    // steps derived from the fraction automatically
    // in 200 MHz units the fraction is of half a pclk, so one more bit goes
    fine_raw = (24'(next_cmp[FRAC_W-1:0]) * 24'(cmp.scale)
      + (cmp.fast ? FRAC_ROUND << 1 : FRAC_ROUND)) >> (cmp.fast ? FRAC_W + 1 : FRAC_W);
    fine_sum = {1'b0, fine_raw[7:0]};
    if (cmp.fast && next_cmp[FRAC_W])
      fine_sum = fine_sum + 9'({1'b0, cmp.scale[7:1]});
    if (fine_sum > STEP_MAX)
      fine_sum = STEP_MAX;
  end

  // ==========================================================
  // pending compare, applied at the period boundary
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_r <= 1'b0;
      pend_cmp_r <= 32'h00000000;
    end
    else if (cmp.load)
    begin
      pend_r <= 1'b1;
      pend_cmp_r <= cmp.compare;
    end
    else if (wrap)
      pend_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 16'h0000;
      cmp_sh_r <= 32'h00000000;
      per_sh_r <= 16'h0000;
      en_sh_r <= 1'b0;
      fine_pos <= 8'h00;
    end
    else if (wrap)
    begin
      cnt_r <= 16'h0000;
      // shadows take effect only from the next period
      cmp_sh_r <= next_cmp;
      per_sh_r <= cmp.period;
      en_sh_r <= cmp.enable;
      fine_pos <= fine_sum[7:0];
    end
    else
      cnt_r <= cnt_r + step;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_out <= 1'b0;
    else
      pulse_out <= en_sh_r && (cnt_r < coarse);
  end
endmodule

// ===== sim/duty_word_tx_chk.sv
/* assertion checker bound to duty_word_tx
   assumes one 100 MHz pclk and async active-low presetn */
`timescale 1ns/1ps
module duty_word_tx_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sample_trig,
  input wire logic cal_done,
  input wire logic cal_start,
  input wire logic pulse_out,
  input wire logic [7:0] fine_pos
);
  logic wait_r;
  wire setup = psel && !penable;
  wire mapped = paddr <= 8'h20 && paddr[1:0] == 2'b00;
  // ==========================================
  // calibration request outstanding
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wait_r <= 1'b0;
    else if (cal_start)
      wait_r <= 1'b1;
    else if (cal_done)
      wait_r <= 1'b0;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_in_time_a: assert property (setup |=> pready)
    else $error("late ready");
  bad_addr_a: assert property (setup && paddr > 8'h20 |=> pslverr)
    else $error("no error on unmapped address");
  good_addr_a: assert property (setup && mapped |=> !pslverr)
    else $error("error on mapped address");
  trig_pulse_a: assert property (sample_trig |=> !sample_trig)
    else $error("trigger longer than one cycle");
  cal_answer_a: assert property (cal_done && wait_r |-> ##[1:3] cal_start)
    else $error("calibration not restarted");
  cal_single_a: assert property (cal_start |-> !wait_r)
    else $error("second calibration request");
  high_min_a: assert property ($rose(pulse_out) |-> pulse_out [*8])
    else $error("high time too short");
  low_min_a: assert property ($fell(pulse_out) |-> !pulse_out [*8])
    else $error("low time too short");
  fine_edge_a: assert property ($changed(fine_pos) |-> ##[0:2] pulse_out)
    else $error("fine code moved mid period");
  cover property (setup && paddr > 8'h20);
  cover property (cal_done && wait_r);
  cover property ($rose(pulse_out));
endmodule
bind duty_word_tx duty_word_tx_chk chk_u (.pclk, .presetn, .paddr, .psel, .penable, .pready,
  .pslverr, .sample_trig, .cal_done, .cal_start, .pulse_out, .fine_pos);

// ===== sim/link_rx_model.sv
/* receiving end of the link: captures rise, fall and next rise of the
   wire and decodes the word; assumes fine_pos counts 1/scale pclk */
`timescale 1ns/1ps
module link_rx_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pulse_out,
  input wire logic [7:0] fine_pos,
  input wire logic [4:0] res,
  input wire logic [7:0] scale,
  output logic [15:0] word,
  output logic [31:0] per_cnt,
  output logic got
);
  // no analogue skew in simulation, so the calibrated offset is zero
  localparam real OFFSET = 0.0;
  logic prev_r;
  int t_r, rise_r, fall_r;
  real fine_r, duty, v, top;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_r <= 1'b0;
      rise_r <= 0;
      fall_r <= 0;
      got <= 1'b0;
    end
    else
    begin
      prev_r <= pulse_out;
      t_r <= t_r + 1;
      got <= 1'b0;
      if (prev_r && !pulse_out)
      begin
        fall_r <= t_r;
        fine_r <= real'(fine_pos) / real'(scale);
      end
      if (pulse_out && !prev_r)
      begin
        rise_r <= t_r;
        if (fall_r > rise_r)
        begin
          // shared resolution, offset and linear map
          top = real'((32'h1 << res) - 32'h1);
          duty = (real'(fall_r - rise_r) + fine_r) / real'(t_r - rise_r);
          v = (duty - OFFSET - 0.1) * 1.25 * (top + 1.0) + 0.5;
          v = (v < 0.0) ? 0.0 : ((v > top) ? top : v);
          word <= 16'($rtoi(v));
          per_cnt <= 32'(t_r - rise_r);
          got <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== sim/tb_duty_word_tx.sv
/* self-checking bench for duty_word_tx: apb registers, encode passes
   and a receiver model on the wire; calibration answered here */
`timescale 1ns/1ps
module tb_duty_word_tx
  import dcl_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_done = 1'b0, cal_done = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q = 32'h0, prdata, per_cnt;
  logic [15:0] conv_word = 16'h0000, rx_word;
  logic [8:0] cal_steps = 9'h040;
  logic [4:0] rx_res = 5'h0b;
  logic [7:0] rx_scale = 8'h40, fine_pos;
  logic pready, pslverr, sample_trig, cal_start, pulse_out, got, err;
  int fails = 0, compares = 0, cyc = 0, cal_cnt = 0;
  always #5 pclk = ~pclk;
  duty_word_tx dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .conv_word, .conv_done, .sample_trig, .cal_steps, .cal_done,
    .cal_start, .pulse_out, .fine_pos);
  link_rx_model rx_u (.pclk, .presetn, .pulse_out, .fine_pos, .res(rx_res),
    .scale(rx_scale), .word(rx_word), .per_cnt, .got);
  // ==========================================
  // delay-line stand-in answers 20 cycles after a request
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    cal_done <= (cal_cnt == 1);
    cal_cnt <= cal_start ? 20 : (cal_cnt > 0 ? cal_cnt - 1 : 0);
    if (cyc == 60000)
    begin
      fails++;
      $display("MISMATCH t=%0t run limit", $time);
      stop_test();
    end
  end
  function automatic logic [31:0] exp_cmp(input logic [15:0] w, input logic [4:0] r);
    logic [63:0] m;
    m = (64'h1 << r) - 64'h1;
    m = 64'(DUTY_LO) + (((w > m) ? m : 64'(w)) * 64'(DUTY_SPAN) >> r);
    return 32'((m * 64'h1f4 + 64'(CMP_ROUND)) >> CMP_SHIFT);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    if (g !== e)
      fails++;
  endtask
  task automatic near(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e && g !== e + 16'h1 && g + 16'h1 !== e)
      $display("MISMATCH t=%0t word %h exp %h", $time, g, e);
    if (g !== e && g !== e + 16'h1 && g + 16'h1 !== e)
      fails++;
  endtask
  // ==========================================
  // apb master, holds the request until pready is sampled
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  task automatic rx(input int k);
    repeat (k) do @(posedge pclk); while (got !== 1'b1);
  endtask
  task automatic t_regs();
    rd_chk(A_CTRL, 32'h4);
    rd_chk(A_RES, 32'hb);
    rd_chk(A_FREQ, 32'hc8);
    rd_chk(A_SAMPLE, 32'h19);
    rd_chk(A_SCALE, 32'h40);
    do apb(A_STATUS, 1'b0, 32'h0); while (q[ST_DIVBUSY] !== 1'b0);
    rd_chk(A_PERIOD, 32'h1f4);
    rd_chk(A_COMPARE, exp_cmp(16'h0, 5'h0b));
    rd_chk(8'h24, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(A_FREQ, 32'h0);
    rd_chk(A_FREQ, 32'hc8);
    $display("t_regs done");
  endtask
  task automatic t_word(input logic [15:0] w, input logic [15:0] e);
    wr(A_MANUAL, {16'h0, w});
    do @(posedge pclk); while (sample_trig !== 1'b1);
    repeat (4) @(posedge pclk);
    rd_chk(A_COMPARE, exp_cmp(w, rx_res));
    rx(2);
    near(rx_word, e);
    chk(per_cnt, 32'h1f4);
    $display("t_word %h done", w);
  endtask
  task automatic t_res();
    wr(A_RES, 32'h8);
    rx_res <= 5'h08;
    t_word(16'h07ff, 16'h00ff);
    wr(A_RES, 32'h14);
    rd_chk(A_RES, 32'h10);
    wr(A_RES, 32'hb);
    rx_res <= 5'h0b;
    $display("t_res done");
  endtask
  task automatic t_conv();
    wr(A_CTRL, 32'h5);
    conv_word <= 16'h02bc;
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
    repeat (3) @(posedge pclk);
    rd_chk(A_COMPARE, exp_cmp(16'h02bc, 5'h0b));
    rx(2);
    near(rx_word, 16'h02bc);
    wr(A_CTRL, 32'h4);
    $display("t_conv done");
  endtask
  task automatic t_freq();
    wr(A_FREQ, 32'h64);
    repeat (24) @(posedge pclk);
    rd_chk(A_PERIOD, 32'h3e8);
    rx(3);
    chk(per_cnt, 32'h3e8);
    wr(A_SAMPLE, 32'h12c);
    rd_chk(A_SAMPLE, 32'h64);
    wr(A_FREQ, 32'hc8);
    wr(A_SAMPLE, 32'h19);
    repeat (24) @(posedge pclk);
    $display("t_freq done");
  endtask
  task automatic t_clk();
    wr(A_CTRL, 32'h6);
    repeat (24) @(posedge pclk);
    rd_chk(A_PERIOD, 32'h3e8);
    rx(3);
    chk(per_cnt, 32'h1f4);
    near(rx_word, 16'h07ff);
    wr(A_CTRL, 32'h4);
    $display("t_clk done");
  endtask
  task automatic t_cal();
    cal_steps <= 9'h100;
    repeat (60) @(posedge pclk);
    apb(A_STATUS, 1'b0, 32'h0);
    chk(q & 32'h1, 32'h1);
    rd_chk(A_SCALE, 32'h40);
    cal_steps <= 9'h0ff;
    repeat (60) @(posedge pclk);
    wr(A_STATUS, 32'h1);
    apb(A_STATUS, 1'b0, 32'h0);
    chk(q & 32'h1, 32'h0);
    rd_chk(A_SCALE, 32'hff);
    $display("t_cal done");
  endtask
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_word(16'h0000, 16'h0000);
    t_word(16'h0400, 16'h0400);
    t_word(16'h07ff, 16'h07ff);
    t_res();
    t_conv();
    t_freq();
    t_clk();
    t_cal();
    stop_test();
  end
endmodule
